// ===== design/scis_pkg.sv
// package: register map, field layouts, reset values and types of the command-input select block
package scis_pkg;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_INERTIA1 = 8'h04;
   localparam logic [7:0] OFF_INERTIA2 = 8'h08;
   localparam logic [7:0] OFF_TLIM_PARAM = 8'h0C;
   localparam logic [7:0] OFF_SPEED_CMD = 8'h10;
   localparam logic [7:0] OFF_TORQUE_CMD = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFF_OUT_SPEED = 8'h24;
   localparam logic [7:0] OFF_OUT_TORQUE = 8'h28;
   localparam logic [7:0] OFF_OUT_TLIM = 8'h2C;
   localparam logic [7:0] OFF_OUT_INERTIA = 8'h30;
   // control register fields
   localparam int CTRL_ZC_MODE_LSB = 0;    // zero_clamp_mode_param, 2 bits
   localparam int CTRL_TLS_LSB = 4;        // torque_limit_select_param, 3 bits
   localparam int CTRL_MODE_LSB = 8;       // control mode, 2 bits
   localparam int CTRL_SPD_DIR_BIT = 12;   // speed direction selection in velocity mode: 1 = sign input
   localparam int CTRL_TRQ_DIR_BIT = 13;   // torque direction selection in torque mode: 1 = sign input
   localparam int CTRL_ERR_CLR_BIT = 16;   // write 1 clears the forced-stop error
   // interrupt bit positions
   localparam int IRQ_FSTOP = 0;
   localparam int IRQ_CLAMP = 1;
   localparam int IRQ_INERTIA = 2;
   localparam int IRQ_W = 3;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] INERTIA_RST = 16'h0064;
   localparam logic [15:0] TLIM_RST = 16'h01F4;
   localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
   // torque limit select codes
   localparam logic [2:0] TLS_ANALOG_BIPOLAR = 3'h0;
   localparam logic [2:0] TLS_ANALOG_UNIPOLAR = 3'h4;
   localparam logic [2:0] TLS_ANALOG_SHARED = 3'h5;

   typedef enum logic [1:0] {SCIS_POS, SCIS_VEL, SCIS_TRQ, SCIS_FULL} scis_mode_t;

   // settings handed to the control loops
   typedef struct packed {
      logic signed [15:0] speed;
      logic signed [15:0] torque;
      logic [15:0] pos_tlim;
      logic [15:0] neg_tlim;
      logic [15:0] inertia;
   } scis_loop_t;

   // discrete inputs from the host
   typedef struct packed {
      logic zero_clamp_input;
      logic speed_sign_input;
      logic torque_sign_input;
      logic forced_stop_input;
      logic inertia_select_input;
   } scis_din_t;
endpackage

// ===== design/scis_sync.sv
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module scis_sync #(
   parameter int WIDTH = 5
) (
   input wire logic pclk,               // clock
   input wire logic presetn,            // async reset, active low
   input wire logic [WIDTH-1:0] d,      // asynchronous levels
   output logic [WIDTH-1:0] q           // synchronised levels
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // scis_sync

// ===== design/scis_tlim.sv
// torque limit source selection: analog inputs or parameter values
`timescale 1ns/1ps
module scis_tlim (
   input wire logic [2:0] sel,                  // torque limit select setting
   input wire logic analog_ok,                  // analog inputs fitted on this variant
   input wire logic signed [15:0] pos_analog,   // positive-direction analog limit
   input wire logic signed [15:0] neg_analog,   // negative-direction analog limit
   input wire logic [15:0] param_lim,           // parameter limit value
   output logic [15:0] pos_lim,                 // positive-direction limit
   output logic [15:0] neg_lim                  // negative-direction limit
);
   function automatic logic [15:0] mag(input logic signed [15:0] v);
      logic signed [15:0] n;
      n = -v;
      mag = v[15] ? 16'(n) : 16'(v);
   endfunction

   always_comb begin
      pos_lim = param_lim;
      neg_lim = param_lim;
      if (analog_ok) begin
         unique case (sel)
            scis_pkg::TLS_ANALOG_BIPOLAR: begin
               // negative input spans -10..0 V, so its magnitude is the limit
               pos_lim = v_pos(pos_analog);
               neg_lim = mag(neg_analog);
            end
            scis_pkg::TLS_ANALOG_UNIPOLAR: begin
               pos_lim = v_pos(pos_analog);
               neg_lim = v_pos(neg_analog);
            end
            scis_pkg::TLS_ANALOG_SHARED: begin
               // one analog input governs both directions
               pos_lim = v_pos(pos_analog);
               neg_lim = v_pos(pos_analog);
            end
            default: begin
               pos_lim = param_lim;
               neg_lim = param_lim;
            end
         endcase
      end
   end

   // unipolar inputs: negative voltages clamp to zero limit
   function automatic logic [15:0] v_pos(input logic signed [15:0] v);
      v_pos = v[15] ? 16'h0000 : 16'(v);
   endfunction
endmodule // scis_tlim

// ===== design/scis_top.sv
// command-input conditioning: zero clamp, sign inputs, forced stop, inertia and torque limit select
`timescale 1ns/1ps
module scis_top #(
   parameter bit HAS_ANALOG = 1'b1    // 0 builds the position-only variant
) (
   input wire logic pclk,                          // apb clock, 50 MHz
   input wire logic presetn,                       // async reset, active low
   input wire logic psel,                          // apb select
   input wire logic penable,                       // apb enable
   input wire logic pwrite,                        // apb write
   input wire logic [scis_pkg::ADDR_W-1:0] paddr,  // apb byte address
   input wire logic [31:0] pwdata,                 // apb write data
   output logic [31:0] prdata,                     // apb read data
   output logic pready,                            // apb ready
   output logic pslverr,                           // apb error on unmapped address
   input wire scis_pkg::scis_din_t din,            // discrete inputs from host pins
   input wire logic signed [15:0] speed_analog,    // digitised speed command voltage
   input wire logic signed [15:0] torque_analog,   // digitised torque command voltage
   input wire logic signed [15:0] pos_torque_limit_analog, // positive limit voltage
   input wire logic signed [15:0] neg_torque_limit_analog, // negative limit voltage
   output scis_pkg::scis_loop_t loop_out,          // settings to control loops
   output logic forced_stop_error,                 // forced-stop alarm
   output logic irq                                // level interrupt
);
   localparam logic ANALOG_OK = HAS_ANALOG;

   scis_pkg::scis_din_t din_s;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [15:0] inertia1_reg, inertia1_next;
   logic [15:0] inertia2_reg, inertia2_next;
   logic [15:0] tlim_param_reg, tlim_param_next;
   logic signed [15:0] spd_cmd_reg, spd_cmd_next;
   logic signed [15:0] trq_cmd_reg, trq_cmd_next;
   logic [scis_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next;
   logic [scis_pkg::IRQ_W-1:0] irq_mask_reg, irq_mask_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic ferr_reg, ferr_next;
   logic irq_reg, irq_next;
   scis_pkg::scis_loop_t loop_reg, loop_next;
   logic clamp_prev_reg, inert_prev_reg;

   logic [1:0] zc_mode;
   logic [2:0] tls;
   scis_pkg::scis_mode_t mode;
   logic spd_dir_sel, trq_dir_sel;
   logic clamp_on;
   logic [15:0] pos_lim, neg_lim;
   logic wr, rd, mapped;
   logic [scis_pkg::IRQ_W-1:0] events;
   logic signed [15:0] spd_src, trq_src, spd_mag, trq_mag;

   scis_sync #(
      .WIDTH($bits(scis_pkg::scis_din_t))
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(din),
      .q(din_s)
   );

   scis_tlim u_tlim (
      .sel(tls),
      .analog_ok(ANALOG_OK),
      .pos_analog(pos_torque_limit_analog),
      .neg_analog(neg_torque_limit_analog),
      .param_lim(tlim_param_reg),
      .pos_lim(pos_lim),
      .neg_lim(neg_lim)
   );

   assign zc_mode = ctrl_reg[scis_pkg::CTRL_ZC_MODE_LSB +: 2];
   assign tls = ctrl_reg[scis_pkg::CTRL_TLS_LSB +: 3];
   assign mode = scis_pkg::scis_mode_t'(ctrl_reg[scis_pkg::CTRL_MODE_LSB +: 2]);
   assign spd_dir_sel = ctrl_reg[scis_pkg::CTRL_SPD_DIR_BIT];
   assign trq_dir_sel = ctrl_reg[scis_pkg::CTRL_TRQ_DIR_BIT];
   assign clamp_on = din_s.zero_clamp_input && (zc_mode != 2'h0);

   // apb: every access answers after one wait state, in its second access cycle
   assign wr = psel && penable && pwrite && !pready_reg;
   assign rd = psel && penable && !pwrite && !pready_reg;

   always_comb begin
      unique case (paddr)
         scis_pkg::OFF_CTRL, scis_pkg::OFF_INERTIA1, scis_pkg::OFF_INERTIA2,
         scis_pkg::OFF_TLIM_PARAM, scis_pkg::OFF_SPEED_CMD, scis_pkg::OFF_TORQUE_CMD,
         scis_pkg::OFF_STATUS, scis_pkg::OFF_IRQ_STAT, scis_pkg::OFF_IRQ_MASK,
         scis_pkg::OFF_OUT_SPEED, scis_pkg::OFF_OUT_TORQUE, scis_pkg::OFF_OUT_TLIM,
         scis_pkg::OFF_OUT_INERTIA: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // register file and bus answer
   always_comb begin
      ctrl_next = ctrl_reg;
      inertia1_next = inertia1_reg;
      inertia2_next = inertia2_reg;
      tlim_param_next = tlim_param_reg;
      spd_cmd_next = spd_cmd_reg;
      trq_cmd_next = trq_cmd_reg;
      irq_mask_next = irq_mask_reg;
      prdata_next = prdata_reg;
      pready_next = psel && penable && !pready_reg;
      pslverr_next = psel && penable && !pready_reg && !mapped;
      if (wr && mapped) begin
         unique case (paddr)
            scis_pkg::OFF_CTRL: ctrl_next = pwdata;
            scis_pkg::OFF_INERTIA1: inertia1_next = pwdata[15:0];
            scis_pkg::OFF_INERTIA2: inertia2_next = pwdata[15:0];
            scis_pkg::OFF_TLIM_PARAM: tlim_param_next = pwdata[15:0];
            scis_pkg::OFF_SPEED_CMD: spd_cmd_next = pwdata[15:0];
            scis_pkg::OFF_TORQUE_CMD: trq_cmd_next = pwdata[15:0];
            scis_pkg::OFF_IRQ_MASK: irq_mask_next = pwdata[scis_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
      // clear strobe is never stored, so a later read of the word returns it as 0
      ctrl_next[scis_pkg::CTRL_ERR_CLR_BIT] = 1'b0;
      if (rd) begin
         unique case (paddr)
            scis_pkg::OFF_CTRL: prdata_next = ctrl_reg;
            scis_pkg::OFF_INERTIA1: prdata_next = {16'h0000, inertia1_reg};
            scis_pkg::OFF_INERTIA2: prdata_next = {16'h0000, inertia2_reg};
            scis_pkg::OFF_TLIM_PARAM: prdata_next = {16'h0000, tlim_param_reg};
            scis_pkg::OFF_SPEED_CMD: prdata_next = {16'h0000, spd_cmd_reg};
            scis_pkg::OFF_TORQUE_CMD: prdata_next = {16'h0000, trq_cmd_reg};
            scis_pkg::OFF_STATUS: prdata_next = {24'h00_0000, ANALOG_OK, ferr_reg, clamp_on, din_s};
            scis_pkg::OFF_IRQ_STAT: prdata_next = {29'h0000_0000, irq_stat_reg};
            scis_pkg::OFF_IRQ_MASK: prdata_next = {29'h0000_0000, irq_mask_reg};
            scis_pkg::OFF_OUT_SPEED: prdata_next = {16'h0000, loop_reg.speed};
            scis_pkg::OFF_OUT_TORQUE: prdata_next = {16'h0000, loop_reg.torque};
            scis_pkg::OFF_OUT_TLIM: prdata_next = {loop_reg.neg_tlim, loop_reg.pos_tlim};
            scis_pkg::OFF_OUT_INERTIA: prdata_next = {16'h0000, loop_reg.inertia};
            default: prdata_next = 32'h0000_0000;
         endcase
      end
   end

   // forced stop, events and interrupt
   always_comb begin
      events = '0;
      events[scis_pkg::IRQ_FSTOP] = din_s.forced_stop_input && !ferr_reg;
      events[scis_pkg::IRQ_CLAMP] = clamp_on && !clamp_prev_reg;
      events[scis_pkg::IRQ_INERTIA] = din_s.inertia_select_input != inert_prev_reg;
      ferr_next = ferr_reg;
      // the clear only takes while the input has gone; a held stop re-arms the error
      if (wr && paddr == scis_pkg::OFF_CTRL && pwdata[scis_pkg::CTRL_ERR_CLR_BIT]) begin
         ferr_next = 1'b0;
      end
      if (din_s.forced_stop_input) begin
         ferr_next = 1'b1;
      end
      irq_stat_next = irq_stat_reg;
      if (rd && paddr == scis_pkg::OFF_IRQ_STAT) begin
         irq_stat_next = '0;
      end
      irq_stat_next = irq_stat_next | events;
      irq_next = |(irq_stat_next & irq_mask_next);
   end

   // command path to the loops
   always_comb begin
      loop_next = loop_reg;
      spd_src = ANALOG_OK ? speed_analog : spd_cmd_reg;
      trq_src = ANALOG_OK ? torque_analog : 16'sh0000;
      spd_mag = spd_src[15] ? 16'(-spd_src) : spd_src;
      trq_mag = trq_src[15] ? 16'(-trq_src) : trq_src;
      loop_next.speed = spd_src;
      if (mode == scis_pkg::SCIS_VEL && spd_dir_sel) begin
         loop_next.speed = din_s.speed_sign_input ? 16'(-spd_mag) : spd_mag;
      end
      if (clamp_on) begin
         loop_next.speed = 16'sh0000;
      end
      loop_next.torque = trq_src;
      if (mode == scis_pkg::SCIS_TRQ && trq_dir_sel) begin
         loop_next.torque = din_s.torque_sign_input ? 16'(-trq_mag) : trq_mag;
      end
      loop_next.pos_tlim = pos_lim;
      loop_next.neg_tlim = neg_lim;
      loop_next.inertia = din_s.inertia_select_input ? inertia2_reg : inertia1_reg;
      if (ferr_next) begin
         // hold no command while the error stands
         loop_next.speed = 16'sh0000;
         loop_next.torque = 16'sh0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= scis_pkg::CTRL_RST;
         inertia1_reg <= scis_pkg::INERTIA_RST;
         inertia2_reg <= scis_pkg::INERTIA_RST;
         tlim_param_reg <= scis_pkg::TLIM_RST;
         spd_cmd_reg <= 16'sh0000;
         trq_cmd_reg <= 16'sh0000;
         irq_stat_reg <= '0;
         irq_mask_reg <= scis_pkg::MASK_RST;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         ferr_reg <= 1'b0;
         irq_reg <= 1'b0;
         loop_reg <= '0;
         clamp_prev_reg <= 1'b0;
         inert_prev_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         inertia1_reg <= inertia1_next;
         inertia2_reg <= inertia2_next;
         tlim_param_reg <= tlim_param_next;
         spd_cmd_reg <= spd_cmd_next;
         trq_cmd_reg <= trq_cmd_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         ferr_reg <= ferr_next;
         irq_reg <= irq_next;
         loop_reg <= loop_next;
         clamp_prev_reg <= clamp_on;
         inert_prev_reg <= din_s.inertia_select_input;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign loop_out = loop_reg;
   assign forced_stop_error = ferr_reg;
   assign irq = irq_reg;
endmodule // scis_top

// ===== verif/scis_top_asserts.sv
// port checker of the command-input select block
`timescale 1ns/1ps
module scis_top_asserts (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb write
   input wire logic [scis_pkg::ADDR_W-1:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire scis_pkg::scis_din_t din, // host pins
   input wire scis_pkg::scis_loop_t loop_out, // loop settings
   input wire logic forced_stop_error // alarm
);
   logic [15:0] ctrl_reg, ctrl_next, in1_reg, in1_next, in2_reg, in2_next, tlp_reg, tlp_next;
   logic wr, clr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadows lag the design by one cycle, so every window below waits them out
   always_comb begin
      wr = psel && penable && pwrite && pready;
      clr = wr && paddr == scis_pkg::OFF_CTRL && pwdata[16];
      ctrl_next = (wr && paddr == scis_pkg::OFF_CTRL) ? pwdata[15:0] : ctrl_reg;
      in1_next = (wr && paddr == scis_pkg::OFF_INERTIA1) ? pwdata[15:0] : in1_reg;
      in2_next = (wr && paddr == scis_pkg::OFF_INERTIA2) ? pwdata[15:0] : in2_reg;
      tlp_next = (wr && paddr == scis_pkg::OFF_TLIM_PARAM) ? pwdata[15:0] : tlp_reg;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= 16'h0000;
         in1_reg <= scis_pkg::INERTIA_RST;
         in2_reg <= scis_pkg::INERTIA_RST;
         tlp_reg <= scis_pkg::TLIM_RST;
      end else begin
         ctrl_reg <= ctrl_next;
         in1_reg <= in1_next;
         in2_reg <= in2_next;
         tlp_reg <= tlp_next;
      end
   end
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held over one cycle");
   a_ready_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("no answer after one wait state");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_stop_raise: assert property ($rose(din.forced_stop_input) |-> ##[1:4] forced_stop_error)
      else $error("forced stop error not raised");
   a_stop_zero: assert property (forced_stop_error && $past(forced_stop_error) |-> loop_out.speed == 16'h0000 && loop_out.torque == 16'h0000)
      else $error("command followed during forced stop");
   a_stop_clear: assert property ($fell(forced_stop_error) |-> clr || $past(clr) || $past(clr, 2) || $past(clr, 3))
      else $error("forced stop error dropped without clear");
   a_clamp_zero: assert property ((ctrl_reg[1:0] != 2'h0 && din.zero_clamp_input) [*5] |-> loop_out.speed == 16'h0000)
      else $error("clamped speed not zero");
   a_inertia_pick: assert property (($stable(in1_reg) && $stable(in2_reg) && $stable(din.inertia_select_input)) [*6] |-> loop_out.inertia == (din.inertia_select_input ? in2_reg : in1_reg))
      else $error("wrong inertia ratio");
   a_tlim_param: assert property ((ctrl_reg[6:4] inside {3'h1, 3'h2, 3'h3, 3'h6} && $stable(ctrl_reg) && $stable(tlp_reg)) [*3] |-> loop_out.pos_tlim == tlp_reg && loop_out.neg_tlim == tlp_reg)
      else $error("parameter torque limit not used");
   c_stop: cover property (forced_stop_error && psel);
   c_err: cover property (pslverr);
   c_clamp: cover property (din.zero_clamp_input && ctrl_reg[1:0] != 2'h0);
endmodule // scis_top_asserts

// ===== verif/scis_host_model.sv
// host controller model: discrete pins and analog command levels
`timescale 1ns/1ps
module scis_host_model (
   output scis_pkg::scis_din_t din, // discrete pins
   output logic signed [15:0] speed_an, // speed command level
   output logic signed [15:0] torque_an, // torque command level
   output logic signed [15:0] pos_lim, // positive limit level
   output logic signed [15:0] neg_lim // negative limit level
);
   initial begin
      din = '0;
      speed_an = 16'sh0000;
      torque_an = 16'sh0000;
      pos_lim = 16'sh0000;
      neg_lim = 16'sh0000;
   end
   // called just after a clock edge; levels then hold until the next call
   task automatic drive(input scis_pkg::scis_din_t d, input logic [15:0] s, t, p, n);
      din <= d;
      speed_an <= s;
      torque_an <= t;
      pos_lim <= p;
      neg_lim <= n;
   endtask
endmodule // scis_host_model

// ===== verif/scis_top_test.sv
// self-checking bench of the command-input select block
`timescale 1ns/1ps
module scis_top_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, forced_stop_error, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed, exp_tl;
   logic signed [15:0] spd, trq, pal, nal;
   logic [15:0] s_v, t_v, p_v, n_v, v, i1, i2, p, n, tp;
   scis_pkg::scis_din_t pins, din;
   scis_pkg::scis_loop_t loop_out;
   logic [72:0] ent;
   logic [72:0] exp_q[$];
   int fail_count, checked, k;
   scis_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din), .speed_analog(spd),
      .torque_analog(trq), .pos_torque_limit_analog(pal), .neg_torque_limit_analog(nal), .loop_out(loop_out),
      .forced_stop_error(forced_stop_error), .irq(irq));
   scis_host_model host (.din(din), .speed_an(spd), .torque_an(trq), .pos_lim(pal), .neg_lim(nal));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // the expectation is queued before the request; the monitor pops it on pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e, input logic er);
      int c;
      exp_q.push_back({a, er, m, e});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (pready !== 1'b1 && c < 40);
      if (c >= 40) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0, m, e, 1'b0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask
   task automatic put;
      host.drive(pins, s_v, t_v, p_v, n_v);
      repeat (5) @(posedge pclk);
   endtask
   task automatic rnd;
      seed = lfsr(seed);
   endtask
   always @(posedge pclk) begin
      if (pready === 1'b1 && exp_q.size() > 0) begin
         ent = exp_q.pop_front();
         chk("pslverr", {31'h0, ent[64]}, {31'h0, pslverr});
         if (ent[63:32] != 32'h0) chk($sformatf("read of %h", ent[72:65]), ent[31:0] & ent[63:32], prdata & ent[63:32]);
      end
   end
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      $display("FAIL watchdog expected end seen hang");
      summarize;
   end
   initial begin
      fail_count = 0;
      checked = 0;
      seed = 32'hcd58_cef4;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {pins, s_v, t_v, p_v, n_v} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(scis_pkg::OFF_CTRL, 32'hFFFF_FFFF, scis_pkg::CTRL_RST);
      rd(scis_pkg::OFF_INERTIA1, 32'hFFFF_FFFF, {16'h0, scis_pkg::INERTIA_RST});
      rd(scis_pkg::OFF_INERTIA2, 32'hFFFF_FFFF, {16'h0, scis_pkg::INERTIA_RST});
      rd(scis_pkg::OFF_TLIM_PARAM, 32'hFFFF_FFFF, {16'h0, scis_pkg::TLIM_RST});
      rd(scis_pkg::OFF_STATUS, 32'h0000_00FF, 32'h0000_0080);
      apb(1'b1, 8'hFC, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 8'hFC, 32'h0, 32'h0, 32'h0, 1'b1);
      $display("test reset_and_map done");
      rnd;
      {i1, i2} = seed;
      wr(scis_pkg::OFF_INERTIA1, {16'h0, i1});
      wr(scis_pkg::OFF_INERTIA2, {16'h0, i2});
      wr(scis_pkg::OFF_SPEED_CMD, {16'h0, i2});
      wr(scis_pkg::OFF_TORQUE_CMD, {16'h0, i1});
      rd(scis_pkg::OFF_SPEED_CMD, 32'h0000_FFFF, {16'h0, i2});
      rd(scis_pkg::OFF_TORQUE_CMD, 32'h0000_FFFF, {16'h0, i1});
      for (k = 0; k < 2; k++) begin
         pins.inertia_select_input = k[0];
         put;
         rd(scis_pkg::OFF_OUT_INERTIA, 32'h0000_FFFF, {16'h0, k ? i2 : i1});
      end
      $display("test inertia done");
      rnd;
      v = {1'b0, seed[14:0]};
      s_v = v;
      pins.zero_clamp_input = 1'b1;
      put;
      for (k = 0; k < 4; k++) begin
         wr(scis_pkg::OFF_CTRL, 32'h0000_0100 | k);
         rd(scis_pkg::OFF_OUT_SPEED, 32'h0000_FFFF, {16'h0, k ? 16'h0 : v});
      end
      pins.zero_clamp_input = 1'b0;
      $display("test clamp done");
      s_v = 16'h0 - v;
      t_v = 16'h0 - v;
      for (k = 0; k < 2; k++) begin
         pins.speed_sign_input = k[0];
         pins.torque_sign_input = k[0];
         put;
         wr(scis_pkg::OFF_CTRL, 32'h0000_1100);
         rd(scis_pkg::OFF_OUT_SPEED, 32'h0000_FFFF, {16'h0, k ? 16'h0 - v : v});
         wr(scis_pkg::OFF_CTRL, 32'h0000_2200);
         rd(scis_pkg::OFF_OUT_TORQUE, 32'h0000_FFFF, {16'h0, k ? 16'h0 - v : v});
      end
      $display("test sign done");
      rnd;
      p = {1'b0, seed[14:0]};
      n = {1'b0, seed[30:16]};
      rnd;
      tp = seed[15:0];
      p_v = p;
      n_v = 16'h0 - n;
      put;
      wr(scis_pkg::OFF_TLIM_PARAM, {16'h0, tp});
      for (k = 0; k < 8; k++) begin
         case (k)
            0: exp_tl = {n, p};
            4: exp_tl = {16'h0, p};
            5: exp_tl = {p, p};
            default: exp_tl = {tp, tp};
         endcase
         wr(scis_pkg::OFF_CTRL, k << 4);
         rd(scis_pkg::OFF_OUT_TLIM, 32'hFFFF_FFFF, exp_tl);
      end
      $display("test torque_limit done");
      pins = '0;
      s_v = v;
      wr(scis_pkg::OFF_CTRL, 32'h0000_0100);
      rd(scis_pkg::OFF_IRQ_STAT, 32'h0, 32'h0);
      pins.forced_stop_input = 1'b1;
      put;
      chk("forced_stop_error", 32'h1, {31'h0, forced_stop_error});
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(scis_pkg::OFF_OUT_SPEED, 32'h0000_FFFF, 32'h0);
      wr(scis_pkg::OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      wr(scis_pkg::OFF_CTRL, 32'h0001_0100);
      chk("forced_stop_error held", 32'h1, {31'h0, forced_stop_error});
      // the inertia select pin fell with the stop pin's rise, so its change bit is set too
      rd(scis_pkg::OFF_IRQ_STAT, 32'h7, 32'h5);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      pins.forced_stop_input = 1'b0;
      put;
      wr(scis_pkg::OFF_CTRL, 32'h0001_0100);
      repeat (3) @(posedge pclk);
      chk("forced_stop_error cleared", 32'h0, {31'h0, forced_stop_error});
      rd(scis_pkg::OFF_OUT_SPEED, 32'h0000_FFFF, {16'h0, v});
      rd(scis_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0100);
      $display("test forced_stop done");
      summarize;
   end
endmodule // scis_top_test
bind scis_top scis_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .din(din),
   .loop_out(loop_out), .forced_stop_error(forced_stop_error));
